//--- include/nco_pkg.sv
// Shared constants and carrier types of the oscillator control block.
// Assumes one clock domain and the byte-wide register port of nco_ctrl.

package nco_pkg;

	// ======================================================================
	// Widths
	localparam int FREQ_W = 48;
	localparam int SER_W = 40;
	localparam int REG_AW = 4;
	localparam int REG_DW = 8;
	localparam int PHASE_W = 16;
	localparam int SINE_W = 16;
	localparam int DAC_W = 14;

	// ======================================================================
	// Register offsets
	localparam logic [3:0] ADDR_CF0 = 4'h0;
	localparam logic [3:0] ADDR_OF0 = 4'h6;
	localparam logic [3:0] ADDR_SER_CFG = 4'hC;
	localparam logic [3:0] ADDR_CTRL = 4'hD;
	localparam logic [3:0] ADDR_MODE = 4'hE;
	localparam logic [3:0] ADDR_UPDATE = 4'hF;
	localparam int NUM_MASTER = 15;
	localparam int FREQ_BYTES = 6;

	// ======================================================================
	// Field positions
	localparam int CTRL_CF_EN_BIT = 7;
	localparam int CTRL_SF_EN_BIT = 6;
	localparam int CTRL_ACC_EN_BIT = 5;
	localparam int STAT_PH_LO_BIT = 0;
	localparam int STAT_PH_HI_BIT = 1;
	localparam int STAT_OFR_BIT = 2;
	localparam int STAT_MODE_OK_BIT = 3;
	localparam int STAT_SETTLED_BIT = 4;
	localparam int SER_SHIFT = FREQ_W - SER_W;

	// ======================================================================
	// Reset values
	localparam logic [47:0] CF_RST = 48'h4000_0000_0000;
	localparam logic [7:0] CTRL_RST = 8'hE0;
	localparam logic [7:0] SER_CFG_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] MODE_OK_A = 8'h00;
	localparam logic [7:0] MODE_OK_B = 8'h30;
	localparam logic [13:0] DAC_MID = 14'h2000;

	// ======================================================================
	// Timing counts in clock cycles at 20 MHz
	localparam int CLK_PERIOD_NS = 50;
	localparam int LAT_OFR_CYC = 14;
	localparam int LAT_RST_CYC = 11;
	localparam int SYNC_STAGES = 2;
	localparam int PIPE_AFTER_DLY = 5;
	localparam int OFR_DLY = LAT_OFR_CYC - SYNC_STAGES - PIPE_AFTER_DLY;

	// ======================================================================
	// Carrier types
	typedef struct packed {
		logic phase_sel_hi;
		logic phase_sel_lo;
		logic offset_freq_enable_pin;
		logic update_n;
	} nco_pins_t;

	typedef struct packed {
		logic [47:0] center_freq_word;
		logic [47:0] offset_freq_word;
		logic [7:0] ctrl;
	} nco_slave_t;

	// Reset value of one master byte.
	function automatic logic [7:0] nco_master_rst(input int idx);
		logic [7:0] v;
		v = 8'h00;
		if (idx < FREQ_BYTES) begin
			v = CF_RST[idx*8 +: 8];
		end else if (idx == int'(ADDR_SER_CFG)) begin
			v = SER_CFG_RST;
		end else if (idx == int'(ADDR_CTRL)) begin
			v = CTRL_RST;
		end else if (idx == int'(ADDR_MODE)) begin
			v = MODE_RST;
		end
		return v;
	endfunction

endpackage

//--- core/nco_sine_map.sv
// Phase to amplitude map with a registered output.
// Assumes an unsigned phase where the top bit weighs half a cycle.

module nco_sine_map #(
	parameter int PW = 16,
	parameter int SW = 16
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Phase in, amplitude out
	input wire logic [PW-1:0] i_phase,
	output logic [SW-1:0] o_amp
);

	// ======================================================================
	// Parabolic half-wave shape, offset binary output.
	logic [PW-2:0] x;
	logic [PW-1:0] x_rest;
	logic [2*PW-2:0] prod;
	logic [PW-1:0] y_raw;
	logic [SW-2:0] y;
	logic [SW-1:0] amp_d;

	assign x = i_phase[PW-2:0];
	assign x_rest = {1'b1, {(PW-1){1'b0}}} - {1'b0, x};
	assign prod = {{PW{1'b0}}, x} * {{(PW-1){1'b0}}, x_rest};
	assign y_raw = prod[2*PW-4 -: PW];
	assign y = y_raw[PW-1] ? {(SW-1){1'b1}} : y_raw[SW-2:0];
	assign amp_d = i_phase[PW-1] ? ({1'b1, {(SW-1){1'b0}}} - {1'b0, y})
		: ({1'b1, {(SW-1){1'b0}}} + {1'b0, y});

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_amp <= {1'b1, {(SW-1){1'b0}}};
		end else begin
			o_amp <= amp_d;
		end
	end

endmodule

//--- core/nco_ctrl.sv
// Oscillator control: master and working registers, modulation pins, phase path.
// Assumes pins and register port are synchronous to I_CLK; the serial tuning
// word arrives already assembled with a one-cycle load strobe.
//
// Added by the designer: the placing of the registers and strobed register access.

module nco_ctrl (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// Register port
	input wire logic [nco_pkg::REG_AW-1:0] I_ADDR,
	input wire logic [nco_pkg::REG_DW-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [nco_pkg::REG_DW-1:0] O_RDATA,
	// Modulation and update pins
	input wire nco_pkg::nco_pins_t I_MOD_PINS,
	// Serial tuning word
	input wire logic [nco_pkg::SER_W-1:0] I_SER_WORD,
	input wire logic I_SER_LOAD,
	// Outputs
	output logic [nco_pkg::DAC_W-1:0] O_DAC_CODE,
	output logic [nco_pkg::FREQ_W-1:0] O_FREQ_INC,
	output logic O_SETTLED
);
	import nco_pkg::*;

	// ======================================================================
	// Pin synchronisers.
	nco_pins_t pins_meta_q;
	nco_pins_t pins_q;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			pins_meta_q <= '{phase_sel_hi: 1'b0, phase_sel_lo: 1'b0,
				offset_freq_enable_pin: 1'b0, update_n: 1'b1};
			pins_q <= '{phase_sel_hi: 1'b0, phase_sel_lo: 1'b0,
				offset_freq_enable_pin: 1'b0, update_n: 1'b1};
		end else begin
			pins_meta_q <= I_MOD_PINS;
			pins_q <= pins_meta_q;
		end
	end

	// ======================================================================
	// Master registers.
	logic [7:0] master_q [NUM_MASTER];
	wire wr_master = I_WR && (I_ADDR != ADDR_UPDATE);
	wire wr_update = I_WR && (I_ADDR == ADDR_UPDATE);

	genvar g;
	generate
		for (g = 0; g < NUM_MASTER; g++) begin : gen_master
			localparam logic [7:0] RST_V = nco_master_rst(g);
			always_ff @(posedge I_CLK) begin
				if (I_RST) begin
					master_q[g] <= RST_V;
				end else if (wr_master && (I_ADDR == 4'(g))) begin
					master_q[g] <= I_WDATA;
				end
			end
		end
	endgenerate

	logic [FREQ_W-1:0] master_cf;
	logic [FREQ_W-1:0] master_of;

	generate
		for (g = 0; g < FREQ_BYTES; g++) begin : gen_assemble
			assign master_cf[g*8 +: 8] = master_q[int'(ADDR_CF0) + g];
			assign master_of[g*8 +: 8] = master_q[int'(ADDR_OF0) + g];
		end
	endgenerate

	// ======================================================================
	// Working registers and update.
	nco_slave_t slave_q;
	wire update_pin = !pins_q.update_n;
	wire do_update = update_pin || wr_update;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			slave_q.center_freq_word <= CF_RST;
			slave_q.offset_freq_word <= '0;
			slave_q.ctrl <= CTRL_RST;
		end else if (do_update) begin
			slave_q.center_freq_word <= master_cf;
			slave_q.offset_freq_word <= master_of;
			slave_q.ctrl <= master_q[ADDR_CTRL];
		end
	end

	// Serial tuning word lands straight in its working register.
	logic [SER_W-1:0] ser_q;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ser_q <= '0;
		end else if (I_SER_LOAD) begin
			ser_q <= I_SER_WORD;
		end
	end

	// ======================================================================
	// Offset enable pipeline.
	logic [OFR_DLY-1:0] ofr_dly_q;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ofr_dly_q <= '0;
		end else begin
			ofr_dly_q <= {ofr_dly_q[OFR_DLY-2:0], pins_q.offset_freq_enable_pin};
		end
	end

	wire ofr_en = ofr_dly_q[OFR_DLY-1];

	// ======================================================================
	// Frequency sum.
	logic [FREQ_W-1:0] cf_term;
	logic [FREQ_W-1:0] of_term;
	logic [FREQ_W-1:0] sf_term;
	logic [FREQ_W-1:0] inc_d;

	assign cf_term = slave_q.ctrl[CTRL_CF_EN_BIT] ? slave_q.center_freq_word : '0;
	assign of_term = ofr_en ? slave_q.offset_freq_word : '0;
	assign sf_term = slave_q.ctrl[CTRL_SF_EN_BIT] ? {ser_q, {SER_SHIFT{1'b0}}} : '0;
	assign inc_d = cf_term + of_term + sf_term;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_FREQ_INC <= '0;
		end else begin
			O_FREQ_INC <= inc_d;
		end
	end

	// ======================================================================
	// Phase accumulator and phase offset.
	logic [FREQ_W-1:0] acc_q;
	logic [PHASE_W-1:0] phase_q;
	logic [1:0] phase_sel;
	logic [PHASE_W-1:0] phase_ofs;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			acc_q <= '0;
		end else if (!slave_q.ctrl[CTRL_ACC_EN_BIT]) begin
			acc_q <= '0;
		end else begin
			acc_q <= acc_q + O_FREQ_INC;
		end
	end

	assign phase_sel = {pins_q.phase_sel_hi, pins_q.phase_sel_lo};
	assign phase_ofs = {phase_sel, {(PHASE_W-2){1'b0}}};

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			phase_q <= '0;
		end else begin
			phase_q <= acc_q[FREQ_W-1 -: PHASE_W] + phase_ofs;
		end
	end

	// ======================================================================
	// Amplitude map.
	logic [SINE_W-1:0] amp;

	nco_sine_map #(
		.PW(PHASE_W),
		.SW(SINE_W)
	) u_map (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_phase(phase_q),
		.o_amp(amp)
	);

	// ======================================================================
	// Output stage and settle counter after reset.
	logic [3:0] settle_q;
	wire settled_d = (settle_q >= 4'(LAT_RST_CYC - 1));

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			settle_q <= '0;
		end else if (!settled_d) begin
			settle_q <= settle_q + 4'h1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_DAC_CODE <= DAC_MID;
			O_SETTLED <= 1'b0;
		end else if (settled_d) begin
			O_DAC_CODE <= amp[SINE_W-1 -: DAC_W];
			O_SETTLED <= 1'b1;
		end
	end

	// ======================================================================
	// Read port.
	logic [7:0] status;
	logic [7:0] rd_data;
	wire mode_ok = (master_q[ADDR_MODE] == MODE_OK_A) || (master_q[ADDR_MODE] == MODE_OK_B);

	always_comb begin
		status = 8'h00;
		status[STAT_PH_LO_BIT] = pins_q.phase_sel_lo;
		status[STAT_PH_HI_BIT] = pins_q.phase_sel_hi;
		status[STAT_OFR_BIT] = ofr_en;
		status[STAT_MODE_OK_BIT] = mode_ok;
		status[STAT_SETTLED_BIT] = O_SETTLED;
	end

	assign rd_data = (I_ADDR == ADDR_UPDATE) ? status : master_q[I_ADDR];

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_RDATA <= 8'h00;
		end else if (I_RD) begin
			O_RDATA <= rd_data;
		end else begin
			O_RDATA <= 8'h00;
		end
	end

endmodule

//--- tb/nco_host.sv
// Host-side pin driver for the oscillator control block.
// Assumes the bench requests pin levels; pins move just after rising edges.
module nco_host (
	// Clock
	input wire logic i_clk,
	// Requests from the bench
	input wire logic i_ofr,
	input wire logic [1:0] i_ph,
	input wire logic i_upd,
	// Pins toward the device
	output nco_pkg::nco_pins_t o_pins
);
	timeunit 1ns;
	timeprecision 1ns;
	import nco_pkg::*;
	logic gap_q = 1'b0;
	initial o_pins = 4'h1;
	// ==========
	// Pin drive, offset enable spaced two cycles apart.
	always @(posedge i_clk) begin
		o_pins.phase_sel_hi <= i_ph[1];
		o_pins.phase_sel_lo <= i_ph[0];
		o_pins.update_n <= !i_upd;
		gap_q <= 1'b0;
		if (i_ofr !== o_pins.offset_freq_enable_pin && !gap_q) begin
			o_pins.offset_freq_enable_pin <= i_ofr;
			gap_q <= 1'b1;
		end
	end
endmodule

//--- tb/nco_ctrl_checker.sv
// Port checks of the oscillator control block.
// Assumes one clock and a synchronous active-high reset.
module nco_ctrl_checker (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// Register port
	input wire logic [nco_pkg::REG_AW-1:0] I_ADDR,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [nco_pkg::REG_DW-1:0] O_RDATA,
	// Pins and serial load
	input wire nco_pkg::nco_pins_t I_MOD_PINS,
	input wire logic I_SER_LOAD,
	// Outputs
	input wire logic [nco_pkg::DAC_W-1:0] O_DAC_CODE,
	input wire logic [nco_pkg::FREQ_W-1:0] O_FREQ_INC,
	input wire logic O_SETTLED
);
	timeunit 1ns;
	timeprecision 1ns;
	import nco_pkg::*;
	logic [4:0] qcnt_q;
	logic [4:0] ocnt_q;
	logic [4:0] pcnt_q;
	wire logic upd_ev = (I_WR && I_ADDR == ADDR_UPDATE) || !I_MOD_PINS.update_n || I_SER_LOAD;
	wire logic [1:0] ph_sel = {I_MOD_PINS.phase_sel_hi, I_MOD_PINS.phase_sel_lo};
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	// ==========
	// Cycles since the last update cause, offset pin change and phase change.
	always_ff @(posedge I_CLK) begin
		qcnt_q <= (I_RST || upd_ev) ? 5'h00 : qcnt_q + {4'h0, qcnt_q != 5'h1F};
		ocnt_q <= (I_RST || $changed(I_MOD_PINS.offset_freq_enable_pin)) ? 5'h00 :
			ocnt_q + {4'h0, ocnt_q != 5'h1F};
		pcnt_q <= (I_RST || $changed(ph_sel)) ? 5'h00 : pcnt_q + {4'h0, pcnt_q != 5'h1F};
	end
	// ==========
	// Assertions.
	rst_out_a: assert property (
		$fell(I_RST) |-> O_DAC_CODE == DAC_MID && !O_SETTLED && O_FREQ_INC == '0)
		else $error("outputs not in reset state");
	rst_freq_a: assert property (
		$fell(I_RST) |=> O_FREQ_INC == CF_RST) else $error("reset increment wrong");
	settle_lat_a: assert property (
		$fell(I_RST) |-> ##10 !O_SETTLED ##1 O_SETTLED) else $error("settle latency wrong");
	settle_hold_a: assert property (
		O_SETTLED |=> O_SETTLED) else $error("settled dropped");
	dac_mid_a: assert property (
		!O_SETTLED |-> O_DAC_CODE == DAC_MID) else $error("output moved before settle");
	ofr_lat_a: assert property (
		$changed(O_FREQ_INC) && qcnt_q >= 5'h0C |-> $past(I_MOD_PINS.offset_freq_enable_pin, 10)
		!= $past(I_MOD_PINS.offset_freq_enable_pin, 11)) else $error("offset latency wrong");
	quiet_a: assert property (
		qcnt_q >= 5'h0C && ocnt_q >= 5'h0C |-> $stable(O_FREQ_INC))
		else $error("increment moved without update");
	stat_pin_a: assert property (
		$past(I_RD) && $past(I_ADDR) == ADDR_UPDATE && pcnt_q >= 5'h04 |-> O_RDATA[1:0] == ph_sel)
		else $error("phase status wrong");
	cover property (I_WR && I_ADDR == ADDR_UPDATE);
	cover property ($rose(O_SETTLED));
	cover property ($changed(I_MOD_PINS.offset_freq_enable_pin));
endmodule

bind nco_ctrl nco_ctrl_checker i_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WR(I_WR),
	.I_RD(I_RD), .O_RDATA(O_RDATA), .I_MOD_PINS(I_MOD_PINS), .I_SER_LOAD(I_SER_LOAD),
	.O_DAC_CODE(O_DAC_CODE), .O_FREQ_INC(O_FREQ_INC), .O_SETTLED(O_SETTLED));

//--- tb/nco_ctrl_tb.sv
// Self-checking bench of the oscillator control block.
// Assumes the host pin model and the bound port checker.
module nco_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import nco_pkg::*;
	typedef struct packed {
		logic [47:0] cf;
		logic [47:0] of;
		logic [39:0] ser;
		logic ofr;
		logic [47:0] inc;
	} nco_row_t;
	localparam nco_row_t ROWS [5] = '{
		'{48'h1, 48'h10, 40'h0, 1'b1, 48'h11},
		'{48'h4000_0000_0000, 48'hC000_0000_0000, 40'h0, 1'b1, 48'h0},
		'{48'h4000_0000_0000, 48'hC000_0000_0000, 40'h0, 1'b0, 48'h4000_0000_0000},
		'{48'h1234_5678_9ABC, 48'h0, 40'h1, 1'b0, 48'h1234_5678_9BBC},
		'{48'hFFFF_FFFF_FFFF, 48'h1, 40'h0, 1'b1, 48'h0}};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [39:0] ser_word = 40'h0;
	logic ser_load = 1'b0;
	logic ofr = 1'b0;
	logic [1:0] ph = 2'h0;
	logic upd = 1'b0;
	nco_pins_t pins;
	logic [7:0] rdata;
	logic [13:0] dac_code;
	logic [47:0] inc;
	logic settled;
	logic [13:0] dac [4];
	int num_errors = 0;
	int cmp_count = 0;
	always #25 clk = ~clk;
	nco_host i_host (.i_clk(clk), .i_ofr(ofr), .i_ph(ph), .i_upd(upd), .o_pins(pins));
	nco_ctrl i_dut (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
		.I_RD(rd_s), .O_RDATA(rdata), .I_MOD_PINS(pins), .I_SER_WORD(ser_word),
		.I_SER_LOAD(ser_load), .O_DAC_CODE(dac_code), .O_FREQ_INC(inc), .O_SETTLED(settled));
	// ==========
	// Shared tasks.
	task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
			num_errors++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask
	task automatic idle(input int n);
		wr_s <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		wr_s <= 1'b0;
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		chk("read data", {40'h0, e}, {40'h0, rdata & m});
		@(posedge clk);
	endtask
	task automatic freq(input logic [47:0] e);
		@(negedge clk);
		chk("increment", e, inc);
		@(posedge clk);
	endtask
	task automatic close_out;
		$display("checks %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		num_errors++;
		close_out();
	end
	// ==========
	// Main sequence.
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		freq(CF_RST);
		for (int i = 0; i < FREQ_BYTES; i++) rd(4'(i), 8'hFF, CF_RST[i*8 +: 8]);
		rd(ADDR_CTRL, 8'hFF, CTRL_RST);
		wr(ADDR_MODE, MODE_OK_A);
		rd(ADDR_UPDATE, 8'h1C, 8'h18);
		foreach (ROWS[r]) begin
			ofr <= ROWS[r].ofr;
			for (int i = 0; i < FREQ_BYTES; i++) begin
				wr(4'(i), ROWS[r].cf[i*8 +: 8]);
				wr(4'(ADDR_OF0 + i), ROWS[r].of[i*8 +: 8]);
			end
			wr_s <= 1'b0;
			ser_word <= ROWS[r].ser;
			ser_load <= 1'b1;
			@(posedge clk);
			ser_load <= 1'b0;
			wr(ADDR_UPDATE, 8'h5A);
			idle(20);
			freq(ROWS[r].inc);
		end
		wr(ADDR_CF0, 8'h02);
		idle(20);
		freq(48'h0);
		upd <= 1'b1;
		@(posedge clk);
		upd <= 1'b0;
		idle(20);
		freq(48'hFFFF_FFFF_FF03);
		for (int k = 0; k < 3; k++) begin
			ofr <= k[0];
			repeat (2) @(posedge clk);
		end
		idle(20);
		freq(48'hFFFF_FFFF_FF02);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_UPDATE, 8'h00);
		for (int p = 0; p < 4; p++) begin
			ph <= 2'(p);
			idle(16);
			rd(ADDR_UPDATE, 8'h03, 8'(p));
			@(negedge clk);
			dac[p] = dac_code;
			@(posedge clk);
		end
		chk("phase order", 48'h1, {47'h0, dac[1] > dac[0] && dac[0] > dac[3]
			&& dac[1] > dac[2] && dac[2] > dac[3]});
		ofr <= 1'b1;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		freq(CF_RST);
		wr(ADDR_MODE, 8'h11);
		rd(ADDR_UPDATE, 8'h08, 8'h00);
		wr(ADDR_MODE, MODE_OK_B);
		rd(ADDR_UPDATE, 8'h08, 8'h08);
		idle(20);
		freq(CF_RST);
		close_out();
	end
endmodule
